// >>> verilog/cst_regs.svh
// constants of the processor state and trap control block
// What this block does
// - thirty-two 32-bit registers reset to zero; register zero reads zero, writes dropped
// - program counter holds next fetch address, resets zero, readable, never written by special move
// - status read returns carry copy in bit 0; writes to bit 0 ignored
// - status write by special move takes effect one cycle after execution
// - status bits 24..31 hold cache, divide, link, break, carry, interrupt, lock flags
// - divide-by-zero flag set when a division by zero occurs
// - stream-link error flag set on get/put type mismatch
// - carry reads one for carry or no borrow, zero for borrow
// - bus lock drives only the data-side peripheral bus lock
// - fetch, decode, execute stages of one cycle each, running in parallel
// - taken plain branch flushes fetch and decode stages, two cycles penalty
// - taken delayed branch discards only fetch stage; decode instruction completes
// - accesses are byte, halfword or word with low address bits forced zero
// - big-endian ordering, most significant byte at lowest address
// - reset or debug reset restores counter and status, fetch starts at zero
// - hardware break abandons instruction, saves address in register 16, jumps 0x18
// - taking a hardware break sets break-in-progress
// - maskable break ignored during break-in-progress; non-maskable break always taken
// - interrupt skips instruction, saves address in register 14, jumps 0x10, clears enable
// - no interrupts during break-in-progress; breaks taken even with interrupts disabled
// - interrupt entry latency one cycle normally to first handler fetch
// - exception skips instruction, saves address in register 17, jumps 0x08
// - return from interrupt loads register plus immediate and sets interrupt enable
// - return from break loads register plus immediate and clears break-in-progress
`ifndef CST_REGS_SVH
`define CST_REGS_SVH
`define CST_RESET_PC     32'h0000_0000
`define CST_RESET_WORD   32'h0000_0000
`define CST_VEC_EXC      32'h0000_0008
`define CST_VEC_IRQ      32'h0000_0010
`define CST_VEC_BRK      32'h0000_0018
`define CST_REG_IRQ      5'h0e
`define CST_REG_BRK      5'h10
`define CST_REG_EXC      5'h11
`define CST_MSW_CC       0
`define CST_MSW_DCE      24
`define CST_MSW_DZ       25
`define CST_MSW_ICE      26
`define CST_MSW_FSL      27
`define CST_MSW_BIP      28
`define CST_MSW_C        29
`define CST_MSW_IE       30
`define CST_MSW_BE       31
`define CST_MSW_RESET    8'h00
`define CST_SEL_PC       1'b0
`define CST_SEL_MSW      1'b1
`endif

// >>> verilog/cst_pkg.sv
// types of the processor state and trap control block
package cst_pkg;
  typedef enum logic [1:0] {
    CST_SZ_BYTE = 2'h0,
    CST_SZ_HALF = 2'h1,
    CST_SZ_WORD = 2'h2
  } cst_size_t;
  typedef enum logic [4:0] {
    CST_EV_NONE  = 5'h00,
    CST_EV_NMBRK = 5'h01,
    CST_EV_BRK   = 5'h02,
    CST_EV_EXC   = 5'h04,
    CST_EV_IRQ   = 5'h08,
    CST_EV_RET   = 5'h10
  } cst_event_t;
  typedef enum logic [2:0] {
    CST_RT_NONE = 3'h1,
    CST_RT_IRQ  = 3'h2,
    CST_RT_BRK  = 3'h4
  } cst_ret_t;
endpackage

// >>> verilog/cst_regfile.sv
// general register file, registered read ports
`timescale 1ns/1ps
`default_nettype none
module cst_regfile
  import cst_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // write port
  input  wire logic             wrEn,
  input  wire logic [4:0]       wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read ports
  input  wire logic [4:0]       rdAddrA,
  input  wire logic [4:0]       rdAddrB,
  output var  logic [WIDTH-1:0] rdDataA,
  output var  logic [WIDTH-1:0] rdDataB
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // -------------------------------------------------------
  // storage
  // -------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (wrEn && wrAddr != 5'h00)
      mem_q[wrAddr] <= wrData;
  end

  // -------------------------------------------------------
  // registered reads, zero register forced
  // -------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rdDataA <= '0;
      rdDataB <= '0;
    end
    else
    begin
      rdDataA <= (rdAddrA == 5'h00) ? '0 : mem_q[rdAddrA];
      rdDataB <= (rdAddrB == 5'h00) ? '0 : mem_q[rdAddrB];
    end
  end
endmodule // cst_regfile
`default_nettype wire

// >>> verilog/cst_core_ctrl.sv
// processor architectural state, pipeline flow and trap entry
`include "cst_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cst_core_ctrl
  import cst_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        debugRst,
  // instruction fetch
  output logic [31:0]      instrAddr,
  output logic             instrReq,
  input  wire logic        instrReady,
  input  wire logic [31:0] instrData,
  // execute-stage control from the decoder
  input  wire logic        exValid,
  input  wire logic        branchTaken,
  input  wire logic        branchDelayed,
  input  wire logic [31:0] branchTarget,
  input  wire logic        retValid,
  input  wire cst_ret_t    retKind,
  input  wire logic [4:0]  retReg,
  input  wire logic [15:0] retImm,
  input  wire logic        moveToSpecial,
  input  wire logic        moveFromSpecial,
  input  wire logic        specialSel,
  input  wire logic [4:0]  srcReg,
  input  wire logic        wbEn,
  input  wire logic [4:0]  wbReg,
  input  wire logic [31:0] wbData,
  input  wire logic        carryValid,
  input  wire logic        carryIn,
  input  wire logic        divByZero,
  input  wire logic        linkTypeError,
  // data memory access
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire cst_size_t   memSize,
  input  wire logic [31:0] memAddrIn,
  input  wire logic [31:0] memStoreIn,
  output logic [31:0]      dataAddr,
  output logic [31:0]      dataWrData,
  output logic [3:0]       dataByteEn,
  output logic             dataReq,
  output logic             dataWe,
  output logic             dataPeriphLock,
  // events
  input  wire logic        interruptIn,
  input  wire logic        externalBreakInput,
  input  wire logic        external_nonmaskable_break_input,
  input  wire logic        exceptionIn,
  // state visible to the decoder
  output logic [31:0]      specialRdData,
  output logic [31:0]      regRdData,
  output logic [31:0]      decodeInstr,
  output logic             decodeValid,
  output logic             dataCacheEn,
  output logic             instrCacheEn,
  output cst_event_t       trapTaken
);
  logic [31:0] pc_q;
  logic [31:0] pc_d;
  logic [7:0]  msw_q;
  logic [31:0] mswPend_q;
  logic        mswPendV_q;
  logic [31:0] fetchPc_q;
  logic        fetchValid_q;
  logic [31:0] decPc_q;
  logic        decValid_q;
  logic [31:0] exPc_q;
  logic        rstAny;
  logic        takeNm;
  logic        takeBrk;
  logic        takeExc;
  logic        takeIrq;
  logic        trapAny;
  logic [31:0] trapVec;
  logic [4:0]  trapReg;
  logic        rfWe;
  logic [4:0]  rfWa;
  logic [31:0] rfWd;
  logic [31:0] rdA;
  logic [31:0] rdB;
  logic [31:0] retBase;
  logic [31:0] retAddr;
  logic [31:0] mswView;

  assign rstAny = srst | debugRst;

  // -------------------------------------------------------
  // helpers
  // -------------------------------------------------------
  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic [31:0] alignAddr(input logic [31:0] a,
                                            input cst_size_t   s);
    unique case (s)
      CST_SZ_HALF: return {a[31:1], 1'b0};
      CST_SZ_WORD: return {a[31:2], 2'b00};
      default:     return a;
    endcase
  endfunction

  // byte enables, lane 3 is the lowest address
  function automatic logic [3:0] laneMask(input logic [1:0] a,
                                          input cst_size_t  s);
    unique case (s)
      CST_SZ_HALF: return a[1] ? 4'h3 : 4'hc;
      CST_SZ_WORD: return 4'hf;
      default:     return 4'h8 >> a;
    endcase
  endfunction

  // -------------------------------------------------------
  // event priority
  // -------------------------------------------------------
  wire break_in_progress_flag = msw_q[`CST_MSW_BIP - 24];
  wire ie  = msw_q[`CST_MSW_IE - 24];

  always_comb
  begin
    takeNm  = external_nonmaskable_break_input;
    takeBrk = !takeNm && externalBreakInput && !break_in_progress_flag;
    takeExc = !takeNm && !takeBrk && exceptionIn;
    takeIrq = !takeNm && !takeBrk && !takeExc && interruptIn
              && ie && !break_in_progress_flag;
    trapAny = decValid_q && (takeNm | takeBrk | takeExc | takeIrq);
    trapVec = (takeNm | takeBrk) ? `CST_VEC_BRK :
              takeExc ? `CST_VEC_EXC : `CST_VEC_IRQ;
    trapReg = (takeNm | takeBrk) ? `CST_REG_BRK :
              takeExc ? `CST_REG_EXC : `CST_REG_IRQ;
  end

  // -------------------------------------------------------
  // register file, trap return address written on entry
  // -------------------------------------------------------
  always_comb
  begin
    rfWe = wbEn;
    rfWa = wbReg;
    rfWd = wbData;
    if (trapAny)
    begin
      rfWe = 1'b1;
      rfWa = trapReg;
      rfWd = decPc_q; // abandoned instruction's address
    end
    else if (moveFromSpecial && exValid)
    begin
      rfWe = wbReg != 5'h00;
      rfWd = specialSel ? mswView : exPc_q;
    end
  end

  cst_regfile #(
    .DEPTH(32),
    .WIDTH(32)
  ) u_regs (
    .ref_clk (ref_clk),
    .srst    (rstAny),
    .wrEn    (rfWe),
    .wrAddr  (rfWa),
    .wrData  (rfWd),
    .rdAddrA (retValid ? retReg : srcReg),
    .rdAddrB (srcReg),
    .rdDataA (rdA),
    .rdDataB (rdB)
  );

  assign retBase = rdA;
  assign retAddr = retBase + sext16(retImm);

  // -------------------------------------------------------
  // status word view: carry copied into bit 0
  // -------------------------------------------------------
  always_comb
  begin
    mswView = {msw_q, 23'h0, msw_q[`CST_MSW_C - 24]};
  end

  // -------------------------------------------------------
  // status word
  // -------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rstAny)
    begin
      msw_q      <= `CST_MSW_RESET;
      mswPendV_q <= 1'b0;
      mswPend_q  <= `CST_RESET_WORD;
    end
    else
    begin
      mswPendV_q <= exValid && moveToSpecial && specialSel == `CST_SEL_MSW;
      mswPend_q  <= rdB;
      if (mswPendV_q)
        msw_q <= mswPend_q[31:24];
      if (carryValid && exValid)
        msw_q[`CST_MSW_C - 24] <= carryIn;
      if (divByZero)
        msw_q[`CST_MSW_DZ - 24] <= 1'b1;
      if (linkTypeError)
        msw_q[`CST_MSW_FSL - 24] <= 1'b1;
      if (retValid && exValid && retKind == CST_RT_IRQ)
        msw_q[`CST_MSW_IE - 24] <= 1'b1;
      if (retValid && exValid && retKind == CST_RT_BRK)
        msw_q[`CST_MSW_BIP - 24] <= 1'b0;
      if (trapAny && takeIrq)
        msw_q[`CST_MSW_IE - 24] <= 1'b0;
      if (trapAny && (takeNm | takeBrk))
        msw_q[`CST_MSW_BIP - 24] <= 1'b1;
    end
  end

  // -------------------------------------------------------
  // program counter and fetch
  // -------------------------------------------------------
  always_comb
  begin
    pc_d = pc_q;
    if (trapAny)
      pc_d = trapVec;
    else if (exValid && retValid)
      pc_d = retAddr;
    else if (exValid && branchTaken)
      pc_d = branchTarget;
    else if (instrReady)
      pc_d = pc_q + 32'h4;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rstAny)
      pc_q <= `CST_RESET_PC;
    else
      pc_q <= pc_d;
  end

  wire redirect = trapAny | (exValid & (retValid | branchTaken));
  wire keepDec  = !trapAny && exValid && !retValid && branchTaken
                  && branchDelayed;

  // -------------------------------------------------------
  // pipeline stages
  // -------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rstAny)
    begin
      fetchValid_q <= 1'b0;
      fetchPc_q    <= `CST_RESET_PC;
      decValid_q   <= 1'b0;
      decPc_q      <= `CST_RESET_PC;
      exPc_q       <= `CST_RESET_PC;
      decodeInstr  <= `CST_RESET_WORD;
    end
    else
    begin
      fetchValid_q <= instrReady && !redirect;
      fetchPc_q    <= pc_q;
      if (instrReady)
        decodeInstr <= instrData;
      if (redirect && !keepDec)
        decValid_q <= 1'b0;
      else
        decValid_q <= fetchValid_q;
      decPc_q <= fetchPc_q;
      exPc_q  <= decPc_q;
    end
  end

  // -------------------------------------------------------
  // outputs
  // -------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rstAny)
    begin
      instrAddr      <= `CST_RESET_PC;
      instrReq       <= 1'b0;
      decodeValid    <= 1'b0;
      specialRdData  <= `CST_RESET_WORD;
      regRdData      <= `CST_RESET_WORD;
      dataCacheEn    <= 1'b0;
      instrCacheEn   <= 1'b0;
      trapTaken      <= CST_EV_NONE;
    end
    else
    begin
      instrAddr     <= pc_d;
      instrReq      <= 1'b1;
      decodeValid   <= decValid_q;
      specialRdData <= specialSel ? mswView : pc_q;
      regRdData     <= rdB;
      dataCacheEn   <= msw_q[`CST_MSW_DCE - 24];
      instrCacheEn  <= msw_q[`CST_MSW_ICE - 24];
      trapTaken     <= !trapAny ? CST_EV_NONE :
                       takeNm  ? CST_EV_NMBRK :
                       takeBrk ? CST_EV_BRK :
                       takeExc ? CST_EV_EXC : CST_EV_IRQ;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rstAny)
    begin
      dataAddr       <= `CST_RESET_WORD;
      dataWrData     <= `CST_RESET_WORD;
      dataByteEn     <= 4'h0;
      dataReq        <= 1'b0;
      dataWe         <= 1'b0;
      dataPeriphLock <= 1'b0;
    end
    else
    begin
      dataReq    <= memReq && !trapAny;
      dataWe     <= memReq && memWrite && !trapAny;
      dataAddr   <= alignAddr(memAddrIn, memSize);
      dataByteEn <= laneMask(memAddrIn[1:0], memSize);
      unique case (memSize)
        CST_SZ_BYTE: dataWrData <= {4{memStoreIn[7:0]}};
        CST_SZ_HALF: dataWrData <= {2{memStoreIn[15:0]}};
        default:     dataWrData <= memStoreIn;
      endcase
      dataPeriphLock <= memReq && msw_q[`CST_MSW_BE - 24];
    end
  end
endmodule // cst_core_ctrl
`default_nettype wire

// >>> verif/cst_core_ctrl_properties.sv
// assertions on the state and trap control ports
`include "cst_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cst_core_ctrl_properties
  import cst_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        debugRst,
  // observed outputs
  input wire logic [31:0] instrAddr,
  input wire logic [31:0] dataAddr,
  input wire logic [3:0]  dataByteEn,
  input wire logic        dataReq,
  input wire logic        dataCacheEn,
  input wire logic        instrCacheEn,
  input wire cst_event_t  trapTaken
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // trap vectors and reset
  // ----------------------------------------
  a_exc_vector: assert property (
    trapTaken == CST_EV_EXC |-> instrAddr == `CST_VEC_EXC)
    else $error("exception vector wrong");
  a_irq_vector: assert property (
    trapTaken == CST_EV_IRQ |-> instrAddr == `CST_VEC_IRQ)
    else $error("interrupt vector wrong");
  a_brk_vector: assert property (
    trapTaken inside {CST_EV_BRK, CST_EV_NMBRK}
    |-> instrAddr == `CST_VEC_BRK) else $error("break vector wrong");
  a_one_trap: assert property ($onehot0(trapTaken))
    else $error("more than one event taken");
  a_reset_fetch: assert property (
    $fell(srst) |-> instrAddr == `CST_RESET_PC && !dataCacheEn
    && !instrCacheEn) else $error("reset state wrong");
  a_dbg_reset: assert property (
    debugRst |=> instrAddr == `CST_RESET_PC && trapTaken == CST_EV_NONE)
    else $error("debug reset did not restart fetch");
  // ----------------------------------------
  // data access lanes
  // ----------------------------------------
  a_word_align: assert property (
    dataReq && dataByteEn == 4'hf |-> dataAddr[1:0] == 2'b00)
    else $error("word not aligned");
  a_half_lane: assert property (
    dataReq && dataByteEn inside {4'hc, 4'h3}
    |-> dataAddr[1:0] == (dataByteEn == 4'hc ? 2'b00 : 2'b10))
    else $error("halfword lane wrong");
  a_byte_lane: assert property (
    dataReq && $countones(dataByteEn) == 1
    |-> dataByteEn == 4'h8 >> dataAddr[1:0]) else $error("byte lane wrong");
  a_lane_legal: assert property (
    dataReq |-> dataByteEn inside {4'h8, 4'h4, 4'h2, 4'h1, 4'hc, 4'h3,
    4'hf}) else $error("illegal lane mask");
  c_irq: cover property (trapTaken == CST_EV_IRQ);
  c_nmbrk: cover property (trapTaken == CST_EV_NMBRK);
  c_word: cover property (dataReq && dataByteEn == 4'hf);
endmodule // cst_core_ctrl_properties
bind cst_core_ctrl cst_core_ctrl_properties cst_core_ctrl_properties_inst (.*);
`default_nettype wire

// >>> verif/cst_imem_model.sv
// instruction memory model answering fetches
`timescale 1ns/1ps
`default_nettype none
module cst_imem_model
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // fetch bus
  input  wire logic        instrReq,
  input  wire logic [31:0] instrAddr,
  output logic             instrReady,
  output logic [31:0]      instrData,
  // pacing
  input  wire logic        slowMode
);
  logic holdQ;
  // one wait state per fetch in slow mode
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      holdQ <= 1'b0;
    else
      holdQ <= slowMode & ~holdQ;
  end
  assign instrReady = instrReq & ~srst & ~holdQ;
  // word carries its address; inverted while no answer is given
  assign instrData = instrReady ? {instrAddr[15:0], 16'h600d}
                                : ~{instrAddr[15:0], 16'h600d};
endmodule // cst_imem_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the state and trap control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cst_pkg::*;
;
  logic        ref_clk, srst, debugRst, instrReq, instrReady, exValid;
  logic [31:0] instrAddr, instrData, branchTarget, wbData, memAddrIn;
  logic [31:0] memStoreIn, dataAddr, dataWrData, specialRdData, regRdData;
  logic [31:0] decodeInstr, a, d;
  logic        branchTaken, branchDelayed, retValid, moveToSpecial;
  logic        moveFromSpecial, specialSel, wbEn, carryValid, carryIn;
  logic        divByZero, linkTypeError, memReq, memWrite, dataReq, dataWe;
  logic        dataPeriphLock, interruptIn, externalBreakInput, exceptionIn;
  logic        external_nonmaskable_break_input, decodeValid, dataCacheEn;
  logic        instrCacheEn, slowMode;
  logic [4:0]  retReg, srcReg, wbReg;
  logic [15:0] retImm;
  logic [3:0]  dataByteEn;
  cst_ret_t    retKind;
  cst_size_t   memSize, s;
  cst_event_t  trapTaken;
  int          errors, tests_run;
  int          cyc = 0;
  cst_core_ctrl cst_core_ctrl_inst (.*);
  cst_imem_model cst_imem_model_inst (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] lanes(cst_size_t z, logic [1:0] x);
    if (z == CST_SZ_BYTE) return 4'h8 >> x;
    if (z == CST_SZ_HALF) return x[1] ? 4'h3 : 4'hc;
    return 4'hf;
  endfunction
  function automatic logic [31:0] align(cst_size_t z, logic [31:0] x);
    if (z == CST_SZ_HALF) return {x[31:1], 1'b0};
    if (z == CST_SZ_WORD) return {x[31:2], 2'b00};
    return x;
  endfunction
  task automatic read_status(input logic [31:0] exp);
    {exValid, moveFromSpecial, specialSel} = 3'b111;
    tick(1);
    {exValid, moveFromSpecial} = 2'b00;
    chk(specialRdData, exp);
  endtask
  task automatic write_reg(input logic [4:0] r, input logic [31:0] v);
    {wbEn, exValid, wbReg, wbData} = {2'b11, r, v};
    tick(1);
    {wbEn, exValid} = 2'b00;
    srcReg = r;
    tick(1);
  endtask
  task automatic write_status(input logic [31:0] v);
    write_reg(5'h03, v);
    {exValid, moveToSpecial, specialSel} = 3'b111;
    tick(1);
    {exValid, moveToSpecial} = 2'b00;
    chk(32'(instrCacheEn), 32'h0);
    tick(2);
    chk(32'(instrCacheEn), 32'(v[26]));
    chk(32'(dataCacheEn), 32'(v[24]));
  endtask
  task automatic mem_access(input cst_size_t z, input logic [31:0] x,
                            input logic lk);
    logic [31:0] v;
    v = $urandom;
    {memReq, memWrite, memAddrIn, memStoreIn} = {1'b1, v[0], x, v};
    memSize = z;
    tick(1);
    memReq = 1'b0;
    chk(32'(dataReq), 32'h1);
    chk(32'(dataByteEn), 32'(lanes(z, x[1:0])));
    chk(dataAddr, align(z, x));
    chk(32'(dataPeriphLock), 32'(lk));
    chk(32'(dataWe), 32'(v[0]));
    if (z == CST_SZ_WORD) chk(dataWrData, v);
    else chk(dataWrData, z == CST_SZ_BYTE ? {4{v[7:0]}} : {2{v[15:0]}});
  endtask
  task automatic wait_trap(input cst_event_t e, input logic [31:0] v);
    int k;
    k = 0;
    tick(1);
    while (trapTaken === CST_EV_NONE && k < 6)
    begin
      tick(1);
      k++;
    end
    chk(32'(trapTaken), 32'(e));
    chk(instrAddr, v);
  endtask
  task automatic quiet(input int n);
    repeat (n)
    begin
      tick(1);
      chk(32'(trapTaken), 32'(CST_EV_NONE));
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {srst, debugRst, exValid, branchTaken, branchDelayed, retValid} = 6'h20;
    {moveToSpecial, moveFromSpecial, specialSel, wbEn, carryValid} = 5'h0;
    {carryIn, divByZero, linkTypeError, memReq, memWrite, slowMode} = 6'h0;
    {interruptIn, externalBreakInput, exceptionIn} = 3'h0;
    external_nonmaskable_break_input = 1'b0;
    {branchTarget, wbData, memAddrIn, memStoreIn} = '0;
    {retReg, srcReg, wbReg, retImm} = '0;
    retKind = CST_RT_NONE;
    memSize = CST_SZ_BYTE;
    errors = 0;
    tests_run = 0;
    void'($urandom(58));
    tick(6);
    srst = 1'b0;
    chk(instrAddr, 32'h0);
    tick(1);
    chk(32'(instrReq), 32'h1);
    read_status(32'h0);
    {divByZero, linkTypeError, carryValid, carryIn, exValid} = 5'h1f;
    tick(1);
    {divByZero, linkTypeError, carryValid, carryIn, exValid} = 5'h0;
    read_status(32'h2a00_0001);
    externalBreakInput = 1'b1;
    wait_trap(CST_EV_BRK, 32'h18);
    externalBreakInput = 1'b0;
    read_status(32'h3a00_0001);
    write_reg(5'h00, 32'hffff_ffff);
    tick(1);
    chk(regRdData, 32'h0);
    d = $urandom;
    write_reg(5'h07, d);
    tick(1);
    chk(regRdData, d);
    mem_access(CST_SZ_WORD, 32'h0000_0103, 1'b0);
    write_status(32'hc500_0001);
    read_status(32'hc500_0000);
    for (int i = 0; i < 24; i++)
    begin
      a = i < 12 ? 32'h3 - 32'(i % 4) : $urandom;
      s = cst_size_t'(2'(i < 12 ? i % 3 : $urandom_range(2)));
      mem_access(s, a, 1'b1);
    end
    interruptIn = 1'b1; // held high until after the break checks; cleared enable stops repeats
    wait_trap(CST_EV_IRQ, 32'h10);
    quiet(8);
    slowMode = 1'b1;
    {exceptionIn, externalBreakInput} = 2'b11;
    external_nonmaskable_break_input = 1'b1;
    wait_trap(CST_EV_NMBRK, 32'h18);
    external_nonmaskable_break_input = 1'b0;
    wait_trap(CST_EV_EXC, 32'h8);
    exceptionIn = 1'b0;
    quiet(8);
    external_nonmaskable_break_input = 1'b1;
    wait_trap(CST_EV_NMBRK, 32'h18);
    {external_nonmaskable_break_input, externalBreakInput} = 2'b00;
    {interruptIn, slowMode} = 2'b00;
    d = $urandom & 32'hffff_fffc;
    {exValid, branchTaken, branchTarget} = {2'b11, d};
    tick(1);
    {exValid, branchTaken} = 2'b00;
    chk(instrAddr, d);
    tick(1);
    chk(32'(decodeValid), 32'h0);
    d = $urandom & 32'hffff_fffc;
    {exValid, branchTaken, branchDelayed, branchTarget} = {3'b111, d};
    tick(1);
    {exValid, branchTaken, branchDelayed} = 3'b000;
    chk(instrAddr, d);
    tick(1);
    chk(32'(decodeValid), 32'h1);
    chk(32'(decodeInstr[15:0]), 32'h600d);
    debugRst = 1'b1;
    tick(1);
    debugRst = 1'b0;
    chk(instrAddr, 32'h0);
    read_status(32'h0);
    give_verdict();
  end
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      give_verdict();
    end
  end
endmodule // tb_top
`default_nettype wire
